// [src/gco_pkg.sv]
package gco_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 64;
    localparam int unsigned OPC_W  = 8;
    localparam int unsigned DEST_W = 7;
    localparam logic [7:0] OPC_BITOR     = 8'h11;
    localparam logic [7:0] OPC_UGTR      = 8'h21;
    localparam logic [7:0] OPC_CARRY     = 8'h2d;
    localparam logic [7:0] OPC_BITXOR    = 8'h30;
    localparam logic [7:0] OPC_CURCYCLES = 8'ha2;
    localparam logic [63:0] CNT_RESET    = 64'h0;
    localparam logic [31:0] FLAG_ONE     = 32'h1;
    localparam logic [31:0] FLAG_ZERO    = 32'h0;
endpackage

// [src/gco_cycle_counter.sv]
`timescale 1ns/1ps
module gco_cycle_counter (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        stall,
    input  wire logic        count_all,
    input  wire logic        sample,
    output logic [63:0]      master,
    output logic [63:0]      slave
);
    typedef struct packed {
        logic [63:0] master;
        logic [63:0] slave;
    } gco_cnt_state_t;

    gco_cnt_state_t s_q;
    gco_cnt_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (count_all || !stall) begin
            s_d.master = s_q.master + 64'h1;
        end
        if (sample) begin
            s_d.slave = s_q.master;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q.master <= gco_pkg::CNT_RESET;
            s_q.slave  <= gco_pkg::CNT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign master = s_q.master;
    assign slave  = s_q.slave;

    AST_CNT_ADVANCE: assert property (@(posedge clk) disable iff (srst)
        (count_all || !stall) |=> master == $past(master) + 64'h1)
        else $error("master counter did not advance");
    AST_CNT_HOLD: assert property (@(posedge clk) disable iff (srst)
        (!count_all && stall) |=> $stable(master))
        else $error("master counter advanced on stall");
    AST_SLAVE_ONLY_SAMPLE: assert property (@(posedge clk) disable iff (srst)
        !sample |=> $stable(slave))
        else $error("slave changed without sample");
    AST_SLAVE_COPY: assert property (@(posedge clk) disable iff (srst)
        sample |=> slave == $past(master))
        else $error("slave not loaded from master");
endmodule

// [src/gco_exec.sv]
`timescale 1ns/1ps
module gco_exec (
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic        ISSUE_VALID,
    input  wire logic [7:0]  OPCODE,
    input  wire logic [31:0] FIRST_SOURCE,
    input  wire logic [31:0] SECOND_SOURCE,
    input  wire logic        GUARD_PRESENT,
    input  wire logic [31:0] GUARD_VALUE,
    input  wire logic [6:0]  DEST_INDEX,
    input  wire logic        STALL,
    input  wire logic        STALL_COUNT_SELECT,
    input  wire logic        JUMP_TAKEN,
    output logic             RESULT_WRITE,
    output logic [6:0]       RESULT_DEST,
    output logic [31:0]      RESULT_DATA,
    output logic [31:0]      SLAVE_COUNT_LOW,
    output logic [31:0]      SLAVE_COUNT_HIGH,
    output logic             OPCODE_KNOWN
);
    typedef struct packed {
        logic        wr;
        logic [6:0]  dest;
        logic [31:0] data;
    } gco_state_t;

    gco_state_t  s_q;
    gco_state_t  s_d;
    logic [63:0] master;
    logic [63:0] slave;
    logic [32:0] sum;
    logic        known;
    logic [31:0] res;
    logic        guard_ok;
    logic        take;

    // slave snapshot keeps low and high word reads coherent
    gco_cycle_counter u_cnt (
        .clk       (CLOCK),
        .srst      (SRST),
        .stall     (STALL),
        .count_all (STALL_COUNT_SELECT),
        .sample    (JUMP_TAKEN),
        .master    (master),
        .slave     (slave)
    );

    always_comb begin
        sum   = {1'b0, FIRST_SOURCE} + {1'b0, SECOND_SOURCE};
        known = 1'b1;
        res   = gco_pkg::FLAG_ZERO;
        unique case (OPCODE)
            gco_pkg::OPC_BITOR:     res = FIRST_SOURCE | SECOND_SOURCE;
            gco_pkg::OPC_BITXOR:    res = FIRST_SOURCE ^ SECOND_SOURCE;
            // borrow arrives here with operands already swapped by the scheduler
            gco_pkg::OPC_UGTR:      res = (FIRST_SOURCE > SECOND_SOURCE) ? gco_pkg::FLAG_ONE
                                                                         : gco_pkg::FLAG_ZERO;
            gco_pkg::OPC_CARRY:     res = sum[32] ? gco_pkg::FLAG_ONE : gco_pkg::FLAG_ZERO;
            gco_pkg::OPC_CURCYCLES: res = master[31:0];
            default:                known = 1'b0;
        endcase
        guard_ok = !GUARD_PRESENT || GUARD_VALUE[0];
        take     = ISSUE_VALID && known && guard_ok;
        s_d      = s_q;
        s_d.wr   = take;
        // a false guard or a refused code leaves data and dest standing
        if (take) begin
            s_d.dest = DEST_INDEX;
            s_d.data = res;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign RESULT_WRITE     = s_q.wr;
    assign RESULT_DEST      = s_q.dest;
    assign RESULT_DATA      = s_q.data;
    assign SLAVE_COUNT_LOW  = slave[31:0];
    assign SLAVE_COUNT_HIGH = slave[63:32];
    assign OPCODE_KNOWN     = known;

    sequence seq_issue_op(logic [7:0] op);
        ISSUE_VALID && OPCODE == op && (!GUARD_PRESENT || GUARD_VALUE[0]);
    endsequence

    AST_OR_RESULT: assert property (@(posedge CLOCK) disable iff (SRST)
        seq_issue_op(gco_pkg::OPC_BITOR) |=> RESULT_WRITE
            && RESULT_DATA == ($past(FIRST_SOURCE) | $past(SECOND_SOURCE)))
        else $error("or result wrong");
    AST_XOR_RESULT: assert property (@(posedge CLOCK) disable iff (SRST)
        seq_issue_op(gco_pkg::OPC_BITXOR) |=> RESULT_WRITE
            && RESULT_DATA == ($past(FIRST_SOURCE) ^ $past(SECOND_SOURCE)))
        else $error("xor result wrong");
    AST_GUARD_BLOCKS: assert property (@(posedge CLOCK) disable iff (SRST)
        (GUARD_PRESENT && !GUARD_VALUE[0]) |=> !RESULT_WRITE && $stable(RESULT_DATA))
        else $error("false guard wrote destination");
    AST_UGTR_RESULT: assert property (@(posedge CLOCK) disable iff (SRST)
        seq_issue_op(gco_pkg::OPC_UGTR) |=>
            RESULT_DATA == {31'h0, $past(FIRST_SOURCE) > $past(SECOND_SOURCE)})
        else $error("compare result wrong");
    AST_CARRY_RESULT: assert property (@(posedge CLOCK) disable iff (SRST)
        seq_issue_op(gco_pkg::OPC_CARRY) |=>
            RESULT_DATA == {31'h0, $past(FIRST_SOURCE) > ~$past(SECOND_SOURCE)})
        else $error("carry result wrong");
    AST_CYCLES_RESULT: assert property (@(posedge CLOCK) disable iff (SRST)
        seq_issue_op(gco_pkg::OPC_CURCYCLES) |=> RESULT_DATA == $past(master[31:0]))
        else $error("counter read wrong");
    AST_ONE_CYCLE: assert property (@(posedge CLOCK) disable iff (SRST)
        RESULT_WRITE |-> $past(ISSUE_VALID) && RESULT_DEST == $past(DEST_INDEX))
        else $error("write without issue one cycle earlier");
    AST_RESET_CLEARS: assert property (@(posedge CLOCK)
        $past(SRST) |-> master == 64'h0 && slave == 64'h0)
        else $error("reset did not clear counter");

    property p_idle_no_write;
        @(posedge CLOCK) disable iff (SRST)
            !ISSUE_VALID |=> !RESULT_WRITE;
    endproperty
    AST_IDLE_NO_WRITE: assert property (p_idle_no_write)
        else $error("write without issue");

    property p_refused_code;
        @(posedge CLOCK) disable iff (SRST)
            (ISSUE_VALID && !OPCODE_KNOWN) |=> !RESULT_WRITE && $stable(RESULT_DATA);
    endproperty
    AST_REFUSED_CODE: assert property (p_refused_code)
        else $error("unknown code wrote destination");

    property p_hold_without_take;
        @(posedge CLOCK) disable iff (SRST)
            !(ISSUE_VALID && OPCODE_KNOWN && (!GUARD_PRESENT || GUARD_VALUE[0]))
                |=> $stable(RESULT_DATA) && $stable(RESULT_DEST);
    endproperty
    AST_HOLD_WITHOUT_TAKE: assert property (p_hold_without_take)
        else $error("result changed without a taken op");

    property p_guard_true_writes;
        @(posedge CLOCK) disable iff (SRST)
            (ISSUE_VALID && OPCODE_KNOWN && GUARD_PRESENT && GUARD_VALUE[0]) |=> RESULT_WRITE;
    endproperty
    AST_GUARD_TRUE_WRITES: assert property (p_guard_true_writes)
        else $error("true guard did not write");

    property p_unguarded_writes;
        @(posedge CLOCK) disable iff (SRST)
            (ISSUE_VALID && OPCODE_KNOWN && !GUARD_PRESENT) |=> RESULT_WRITE;
    endproperty
    AST_UNGUARDED_WRITES: assert property (p_unguarded_writes)
        else $error("unguarded op did not write next cycle");

    property p_flag_upper_zero;
        @(posedge CLOCK) disable iff (SRST)
            (ISSUE_VALID && (OPCODE == gco_pkg::OPC_UGTR || OPCODE == gco_pkg::OPC_CARRY)
                && (!GUARD_PRESENT || GUARD_VALUE[0])) |=> RESULT_DATA[31:1] == 31'h0;
    endproperty
    AST_FLAG_UPPER_ZERO: assert property (p_flag_upper_zero)
        else $error("flag result has upper bits set");

    property p_ugtr_equal_zero;
        @(posedge CLOCK) disable iff (SRST)
            (ISSUE_VALID && OPCODE == gco_pkg::OPC_UGTR && (!GUARD_PRESENT || GUARD_VALUE[0])
                && FIRST_SOURCE == SECOND_SOURCE) |=> RESULT_DATA == gco_pkg::FLAG_ZERO;
    endproperty
    AST_UGTR_EQUAL_ZERO: assert property (p_ugtr_equal_zero)
        else $error("equal operands gave a borrow");

    property p_carry_wrap;
        @(posedge CLOCK) disable iff (SRST)
            seq_issue_op(gco_pkg::OPC_CARRY) |=> RESULT_DATA ==
                ((32'($past(FIRST_SOURCE) + $past(SECOND_SOURCE)) < $past(FIRST_SOURCE))
                    ? gco_pkg::FLAG_ONE : gco_pkg::FLAG_ZERO);
    endproperty
    AST_CARRY_WRAP: assert property (p_carry_wrap)
        else $error("carry disagrees with wrapped sum");

    property p_or_superset;
        @(posedge CLOCK) disable iff (SRST)
            seq_issue_op(gco_pkg::OPC_BITOR) |=> (RESULT_DATA & $past(FIRST_SOURCE)) == $past(FIRST_SOURCE);
    endproperty
    AST_OR_SUPERSET: assert property (p_or_superset)
        else $error("or result lost first source bits");

    property p_xor_undo;
        @(posedge CLOCK) disable iff (SRST)
            seq_issue_op(gco_pkg::OPC_BITXOR) |=> (RESULT_DATA ^ $past(SECOND_SOURCE)) == $past(FIRST_SOURCE);
    endproperty
    AST_XOR_UNDO: assert property (p_xor_undo)
        else $error("xor result not reversible");

    // counter reads taken on a counting cycle and on a frozen one
    sequence seq_read_counting;
        ISSUE_VALID && OPCODE == gco_pkg::OPC_CURCYCLES && (!GUARD_PRESENT || GUARD_VALUE[0])
            && (STALL_COUNT_SELECT || !STALL);
    endsequence
    sequence seq_read_frozen;
        ISSUE_VALID && OPCODE == gco_pkg::OPC_CURCYCLES && (!GUARD_PRESENT || GUARD_VALUE[0])
            && !STALL_COUNT_SELECT && STALL;
    endsequence

    property p_cycles_advance;
        @(posedge CLOCK) disable iff (SRST)
            seq_read_counting ##1 seq_issue_op(gco_pkg::OPC_CURCYCLES)
                |=> RESULT_DATA == $past(RESULT_DATA) + 32'h1;
    endproperty
    AST_CYCLES_ADVANCE: assert property (p_cycles_advance)
        else $error("back to back reads did not step by one");

    property p_cycles_frozen;
        @(posedge CLOCK) disable iff (SRST)
            seq_read_frozen ##1 seq_issue_op(gco_pkg::OPC_CURCYCLES)
                |=> RESULT_DATA == $past(RESULT_DATA);
    endproperty
    AST_CYCLES_FROZEN: assert property (p_cycles_frozen)
        else $error("counter moved on a stalled cycle");

    property p_reset_outputs;
        @(posedge CLOCK)
            $past(SRST) |-> !RESULT_WRITE && RESULT_DATA == 32'h0 && RESULT_DEST == 7'h0;
    endproperty
    AST_RESET_OUTPUTS: assert property (p_reset_outputs)
        else $error("reset left result outputs set");
endmodule

// [bench/gco_regfile_model.sv]
`timescale 1ns/1ps
// destination registers behind the write port; start cleared so untouched ones read 0
module gco_regfile_model (
    input wire logic        CLOCK,
    input wire logic        WE,
    input wire logic [6:0]  DEST,
    input wire logic [31:0] DATA
);
    logic [31:0] regs [128] = '{default: 32'h0};
    always @(posedge CLOCK) begin
        if (WE === 1'b1) begin
            regs[DEST] <= DATA;
        end
    end
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0]  opc;
        logic [31:0] a;
        logic [31:0] b;
        logic [1:0]  g;
        logic        we;
        logic [31:0] r;
    } gco_row_t;
    logic        clk = 0, srst = 1, iv = 0, gp = 0, stl = 0, sel = 0, jmp = 0;
    logic [7:0]  opc = 0;
    logic [31:0] fa = 0, fb = 0, gv = 0, v0, dat_o, sl, sh;
    logic [6:0]  dst = 0, dst_o;
    logic        we_o, known;
    int          err_total = 0, n_checks = 0;
    // g: bit1 guard attached, bit0 guard lsb
    gco_row_t    rows [13] = '{
        '{8'h11, 32'hf310ffff, 32'hffff0000, 2'h0, 1'b1, 32'hffffffff},
        '{8'h11, 32'hf310ffff, 32'h88888888, 2'h2, 1'b0, 32'h0},
        '{8'h11, 32'hf310ffff, 32'h88888888, 2'h3, 1'b1, 32'hfb98ffff},
        '{8'h30, 32'hf310ffff, 32'hffff0000, 2'h0, 1'b1, 32'h0cefffff},
        '{8'h30, 32'h11119999, 32'h88888888, 2'h0, 1'b1, 32'h99991111},
        '{8'h30, 32'h55555555, 32'hf310ffff, 2'h2, 1'b0, 32'h0},
        '{8'h21, 32'hfffffffc, 32'h00000002, 2'h0, 1'b1, 32'h1},
        '{8'h21, 32'hfffffffc, 32'hfffffffc, 2'h0, 1'b1, 32'h0},
        '{8'h21, 32'h00000000, 32'hffffffff, 2'h3, 1'b1, 32'h0},
        '{8'h2d, 32'h00000002, 32'hfffffffc, 2'h0, 1'b1, 32'h0},
        '{8'h2d, 32'h00000004, 32'hfffffffc, 2'h0, 1'b1, 32'h1},
        '{8'h2d, 32'hfffffffc, 32'hfffffffc, 2'h2, 1'b0, 32'h0},
        '{8'h10, 32'h12345678, 32'h0, 2'h0, 1'b0, 32'h0}};
    gco_exec u_dut (.CLOCK(clk), .SRST(srst), .ISSUE_VALID(iv), .OPCODE(opc), .FIRST_SOURCE(fa),
        .SECOND_SOURCE(fb), .GUARD_PRESENT(gp), .GUARD_VALUE(gv), .DEST_INDEX(dst), .STALL(stl),
        .STALL_COUNT_SELECT(sel), .JUMP_TAKEN(jmp), .RESULT_WRITE(we_o), .RESULT_DEST(dst_o),
        .RESULT_DATA(dat_o), .SLAVE_COUNT_LOW(sl), .SLAVE_COUNT_HIGH(sh), .OPCODE_KNOWN(known));
    gco_regfile_model u_rf (.CLOCK(clk), .WE(we_o), .DEST(dst_o), .DATA(dat_o));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // issue at the coming rising edge, return at the falling edge where the answer stands
    task automatic op(input logic [7:0] o, input logic [31:0] a, b, input logic [1:0] g, input logic [6:0] d);
        iv = 1;
        opc = o;
        fa = a;
        fb = b;
        gp = g[1];
        gv = {31'h2, g[0]};
        dst = d;
        @(negedge clk);
    endtask
    initial begin
        #80000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (10) @(negedge clk);
        chk(dat_o, 32'h0);
        chk(sl, 32'h0);
        srst = 0;
        foreach (rows[i]) begin
            op(rows[i].opc, rows[i].a, rows[i].b, rows[i].g, 7'(i + 1));
            chk({31'h0, we_o}, {31'h0, rows[i].we});
            chk({31'h0, known}, {31'h0, rows[i].opc != 8'h10});
            if (rows[i].we) chk(dat_o, rows[i].r);
            if (rows[i].we) chk({25'h0, dst_o}, 32'(i + 1));
        end
        iv = 0;
        repeat (2) @(negedge clk);
        foreach (rows[i]) chk(u_rf.regs[i + 1], rows[i].r);
        stl = 1;
        op(8'ha2, 32'h0, 32'h0, 2'h0, 7'h7f);
        v0 = dat_o;
        op(8'ha2, 32'h0, 32'h0, 2'h0, 7'h7f);
        chk(dat_o, v0);
        sel = 1;
        // a read returns the count at its issue edge; the step shows on the next read
        op(8'ha2, 32'h0, 32'h0, 2'h3, 7'h7f);
        chk(dat_o, v0);
        {stl, sel, jmp} = 3'b001;
        op(8'ha2, 32'h0, 32'h0, 2'h0, 7'h7f);
        jmp = 0;
        chk(dat_o, v0 + 32'h1);
        chk(sl, v0 + 32'h1);
        chk(sh, 32'h0);
        op(8'ha2, 32'h0, 32'h0, 2'h0, 7'h7f);
        chk(dat_o, v0 + 32'h2);
        chk(sl, v0 + 32'h1);
        {iv, srst} = 2'b01;
        @(negedge clk);
        srst = 0;
        chk({31'h0, we_o}, 32'h0);
        chk(sl, 32'h0);
        op(8'ha2, 32'h0, 32'h0, 2'h0, 7'h7f);
        chk(dat_o, 32'h0);
        finish_test();
    end
endmodule
